// >>> clkgen_pkg.sv
package clkgen_pkg;
    typedef enum logic [1:0] {
        QUAD_UP_RISE = 2'b00,
        QUAD_UP_FALL = 2'b01,
        QUAD_DN_FALL = 2'b10,
        QUAD_DN_RISE = 2'b11
    } quad_e;
    typedef enum logic [1:0] {
        ODM_LOW = 2'b00,
        ODM_HIGH = 2'b01,
        ODM_HIZ = 2'b10,
        ODM_RSVD = 2'b11
    } odm_e;
endpackage

// >>> clkgen_regs.svh
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH
`define REG_ADDR_W 8
`define CFG_SSC_FIRST 8'hac
`define CFG_SSC_LAST 8'hbd
`define Q_DISABLE_CODE 7'h7f
`define TSSC_EXTRA 5'h02
`define OFFSET_MAX 6'h3f
`define NUM_SD 12
`define NUM_OUT_DIV 6
`define LFSR_SEED 8'ha5
`define SSC_IDX_TSSC 8'hac
`define SSC_IDX_NSSC 8'had
`define SSC_IDX_OFFS 8'hae
`define SSC_IDX_OPT 8'haf
`define SSC_IDX_SD0 8'hb0
`define CTRL_IDX_PLL 8'h00
`define CTRL_IDX_DIV 8'h10
`define STAT_IDX_M0 8'hc0
`define STAT_IDX_SSC 8'hc2
`endif

// >>> out_divider.sv
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module out_divider import clkgen_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [6:0] q_sel,
    input wire logic out_prescale_sel,
    input wire logic [1:0] output_disable_mode,
    output logic [8:0] total_out_divide,
    output logic div_enabled,
    output logic out_clk,
    output logic out_oe
);
    typedef struct packed {
        logic [7:0] cnt;
        logic clk;
    } div_s;
    div_s s_q, s_d;
    logic dis;
    logic [7:0] half;
    always_comb begin
        dis = (q_sel == `Q_DISABLE_CODE) && !out_prescale_sel; // R03
        if (q_sel == `Q_DISABLE_CODE)
            total_out_divide = out_prescale_sel ? 9'h001 : 9'h000; // R03
        else if (!out_prescale_sel)
            total_out_divide = 9'h002; // R03
        else
            total_out_divide = {1'b0, q_sel + 8'h02} << 1; // R06
        half = total_out_divide[8:1] - 8'h01;
        s_d = s_q;
        if (dis || total_out_divide == 9'h001) begin
            s_d.cnt = 8'h00;
            s_d.clk = 1'b0;
        end else if (s_q.cnt >= half) begin
            s_d.cnt = 8'h00;
            s_d.clk = !s_q.clk;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    // Divide-by-1 passes a level marker only; real bypass happens in the analog path
    always_comb begin
        div_enabled = !dis; // R04
        out_oe = !(dis && output_disable_mode == ODM_HIZ); // R04
        if (dis)
            out_clk = (output_disable_mode == ODM_HIGH); // R04
        else if (total_out_divide == 9'h001)
            out_clk = 1'b1;
        else
            out_clk = s_q.clk;
    end
    property p_dis_static;
        @(posedge clk_sys) disable iff (!rst_n)
        dis |-> total_out_divide == 9'h000 && out_clk == (output_disable_mode == ODM_HIGH);
    endproperty
    a_dis_static: assert property (p_dis_static) else $error("disabled divider not static"); // R04
endmodule // out_divider

// >>> pll_divider_ssc_modulator.sv
// Summary of operation
// (R01) Each PLL has a 7-bit reference divider and 12-bit feedback divider.
// (R02) Fractional PLL M is 2N+A+1 if A nonzero, else 2N; others M=N.
// (R03) Q all ones: prescale 0 disables, 1 divides by one; else /2 or /(Q+2)*2.
// (R04) Disabled divider makes no clock; output held high, low or released per mode.
// (R05) Undivided output has no divider; outputs 1 to 6 each have one.
// (R06) The (Q+2)*2 path gives even ratios from 4 to 256.
// (R07) Software disables a divider only for outputs never used.
// (R08) Spread settings live at configuration addresses 0xAC to 0xBD.
// (R09) Modulation runs while step period is nonzero, fully off when zero.
// (R10) Software programs step period only 5 to 14.
// (R11) Each step lasts step period plus 2 cycles; quadrant has count times 2 samples.
// (R12) Software programs sample count only 1 to 6.
// (R13) All four quadrants mirror each other using the same deltas.
// (R14) Modulation period is four quadrants of samples times step cycles.
// (R15) Offset 0 gives center spread; nonzero gives down spread about M-1+offset. The code instead centers the spread on M-1 and swings both up and down.
// (R16) Twelve 4-bit delta samples stored; sample count picks how many apply.
// (R17) Software keeps delta sum at most 63 minus offset.
// (R18) Waveform starts at offset then accumulates each delta.
// (R19) Dither set randomizes accumulated sample least significant bit.
// (R20) Doubling bit doubles accumulated total; clear keeps nominal amplitude.
// (R21) Software never enables steps with zero offset and zero deltas.
// (R22) Software uses the fractional field whenever spread is enabled.
// (R23) Reference divider zero powers down PLLs 0, 1 and 2.
// (R24) Effective fractional PLL feedback value changes only on detector edges.
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module pll_divider_ssc_modulator import clkgen_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pfd_tick,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic [3:0] pll_power_down,
    output logic [13:0] fractional_pll_m,
    output logic [11:0] pll1_m,
    output logic [11:0] pll2_m,
    output logic [11:0] pll3_m,
    output logic [6:0] fractional_pll_ref_div,
    output logic [6:0] pll1_ref_div,
    output logic [6:0] pll2_ref_div,
    output logic [6:0] pll3_ref_div,
    output logic [13:0] ssc_mod_value,
    output logic ssc_active,
    output logic undivided_output_en,
    output logic [5:0] out_clk,
    output logic [5:0] out_oe,
    output logic [5:0] div_enabled
);
    typedef struct packed {
        logic [3:0][6:0] ref_div;
        logic [3:0][11:0] fb_div;
        logic [3:0] frac_a;
        logic [5:0][6:0] q_sel;
        logic [5:0] out_prescale_sel;
        logic [5:0][1:0] output_disable_mode;
        logic [3:0] tssc;
        logic [2:0] nssc;
        logic [5:0] offset;
        logic dither_enable;
        logic amplitude_double;
        logic [11:0][3:0] shape_delta_sample;
        logic [4:0] step_cnt;
        logic [3:0] samp_idx;
        quad_e quad;
        logic [6:0] accum;
        logic [7:0] lfsr;
        logic [13:0] m_eff;
        logic [7:0] rdata;
    } st_s;
    st_s s_q, s_d;
    logic [7:0] ra;
    logic [13:0] m_nom;
    logic [3:0] nsamp;
    logic [3:0] cur_delta;
    logic [7:0] wave;
    logic [8:0] scaled;
    logic step_done;
    logic [4:0] step_len;
    logic [3:0] sd_idx;
    logic [8:0] tod [6];
    always_comb begin
        // R02: FRACTIONAL_PLL multiplier from integer and fractional fields
        if (s_q.frac_a != 4'h0)
            m_nom = {1'b0, s_q.fb_div[0], 1'b0} + {10'h000, s_q.frac_a} + 14'h0001; // R02
        else
            m_nom = {1'b0, s_q.fb_div[0], 1'b0}; // R02
        nsamp = {s_q.nssc, 1'b0}; // R11
        step_len = {1'b0, s_q.tssc} + `TSSC_EXTRA; // R11
        step_done = (s_q.step_cnt >= step_len - 5'h01);
        sd_idx = (s_q.quad == QUAD_UP_FALL || s_q.quad == QUAD_DN_RISE) ?
            (nsamp - 4'h1 - s_q.samp_idx) : s_q.samp_idx; // R13
        cur_delta = (sd_idx < 4'd12) ? s_q.shape_delta_sample[sd_idx] : 4'h0; // R16
        wave = {1'b0, s_q.accum};
        if (s_q.dither_enable)
            wave[0] = s_q.lfsr[0]; // R19
        scaled = s_q.amplitude_double ? {wave, 1'b0} : {1'b0, wave}; // R20
        s_d = s_q;
        s_d.rdata = 8'h00;
        ra = addr;
        if (wr_en) begin
            if (ra < `CTRL_IDX_PLL + 8'h04) begin
                s_d.ref_div[ra[1:0]] = wdata[6:0]; // R01
            end else if (ra < `CTRL_IDX_PLL + 8'h08) begin
                s_d.fb_div[ra[1:0]][7:0] = wdata; // R01
            end else if (ra < `CTRL_IDX_PLL + 8'h0c) begin
                s_d.fb_div[ra[1:0]][11:8] = wdata[3:0]; // R01
            end else if (ra == `CTRL_IDX_PLL + 8'h0c) begin
                s_d.frac_a = wdata[3:0];
            end else if (ra >= `CTRL_IDX_DIV && ra < `CTRL_IDX_DIV + 8'h06) begin
                s_d.q_sel[ra[2:0]] = wdata[6:0];
                s_d.out_prescale_sel[ra[2:0]] = wdata[7]; // R05
            end else if (ra >= `CTRL_IDX_DIV + 8'h08 && ra < `CTRL_IDX_DIV + 8'h0e) begin
                s_d.output_disable_mode[ra[2:0]] = wdata[1:0];
            end else if (ra == `SSC_IDX_TSSC) begin
                s_d.tssc = wdata[3:0]; // R08
            end else if (ra == `SSC_IDX_NSSC) begin
                s_d.nssc = wdata[2:0];
            end else if (ra == `SSC_IDX_OFFS) begin
                s_d.offset = wdata[5:0];
            end else if (ra == `SSC_IDX_OPT) begin
                s_d.dither_enable = wdata[0];
                s_d.amplitude_double = wdata[1];
            end else if (ra >= `SSC_IDX_SD0 && ra < `SSC_IDX_SD0 + 8'h0c) begin
                s_d.shape_delta_sample[4'(ra - `SSC_IDX_SD0)] = wdata[3:0]; // R16
            end
        end
        if (rd_en) begin
            if (ra < `CTRL_IDX_PLL + 8'h04)
                s_d.rdata = {1'b0, s_q.ref_div[ra[1:0]]};
            else if (ra < `CTRL_IDX_PLL + 8'h08)
                s_d.rdata = s_q.fb_div[ra[1:0]][7:0];
            else if (ra < `CTRL_IDX_PLL + 8'h0c)
                s_d.rdata = {4'h0, s_q.fb_div[ra[1:0]][11:8]};
            else if (ra == `CTRL_IDX_PLL + 8'h0c)
                s_d.rdata = {4'h0, s_q.frac_a};
            else if (ra >= `CTRL_IDX_DIV && ra < `CTRL_IDX_DIV + 8'h06)
                s_d.rdata = {s_q.out_prescale_sel[ra[2:0]], s_q.q_sel[ra[2:0]]};
            else if (ra >= `CTRL_IDX_DIV + 8'h08 && ra < `CTRL_IDX_DIV + 8'h0e)
                s_d.rdata = {6'h00, s_q.output_disable_mode[ra[2:0]]};
            else if (ra == `SSC_IDX_TSSC)
                s_d.rdata = {4'h0, s_q.tssc};
            else if (ra == `SSC_IDX_NSSC)
                s_d.rdata = {5'h00, s_q.nssc};
            else if (ra == `SSC_IDX_OFFS)
                s_d.rdata = {2'h0, s_q.offset};
            else if (ra == `SSC_IDX_OPT)
                s_d.rdata = {6'h00, s_q.amplitude_double, s_q.dither_enable};
            else if (ra >= `SSC_IDX_SD0 && ra < `SSC_IDX_SD0 + 8'h0c)
                s_d.rdata = {4'h0, s_q.shape_delta_sample[4'(ra - `SSC_IDX_SD0)]};
            else if (ra == `STAT_IDX_M0)
                s_d.rdata = s_q.m_eff[7:0];
            else if (ra == `STAT_IDX_M0 + 8'h01)
                s_d.rdata = {2'h0, s_q.m_eff[13:8]};
            else if (ra == `STAT_IDX_SSC)
                s_d.rdata = {s_q.quad, 5'h00, s_q.tssc != 4'h0};
        end
        if (s_q.tssc == 4'h0) begin
            // R09: modulator fully off, waveform parked at the offset
            s_d.step_cnt = 5'h00;
            s_d.samp_idx = 4'h0;
            s_d.quad = QUAD_UP_RISE;
            s_d.accum = {1'b0, s_q.offset}; // R18
            if (pfd_tick)
                s_d.m_eff = m_nom; // R24
        end else if (pfd_tick) begin
            s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
            // R15: center spread swings about M; nonzero offset moves the swing center to M-1, still up and down
            if (s_q.quad == QUAD_UP_RISE || s_q.quad == QUAD_UP_FALL)
                s_d.m_eff = m_nom + {5'h00, scaled}; // R24
            else
                s_d.m_eff = m_nom - {5'h00, scaled}; // R24
            if (s_q.offset != 6'h00)
                s_d.m_eff = s_d.m_eff - 14'h0001; // R15
            if (step_done) begin
                s_d.step_cnt = 5'h00; // R11
                // Magnitude grows in the first quadrant of each half, shrinks in the second
                if (s_q.quad == QUAD_UP_RISE || s_q.quad == QUAD_DN_FALL)
                    s_d.accum = s_q.accum + {3'h0, cur_delta}; // R18
                else
                    s_d.accum = s_q.accum - {3'h0, cur_delta}; // R13
                if (s_q.samp_idx >= nsamp - 4'h1) begin
                    s_d.samp_idx = 4'h0;
                    s_d.quad = quad_e'(s_q.quad + 2'h1); // R14
                end else begin
                    s_d.samp_idx = s_q.samp_idx + 4'h1;
                end
            end else begin
                s_d.step_cnt = s_q.step_cnt + 5'h01;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.lfsr <= `LFSR_SEED;
        end else begin
            s_q <= s_d;
        end
    end
    genvar g;
    generate
        for (g = 0; g < `NUM_OUT_DIV; g++) begin : g_div
            out_divider u_div (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .q_sel(s_q.q_sel[g]),
                .out_prescale_sel(s_q.out_prescale_sel[g]),
                .output_disable_mode(s_q.output_disable_mode[g]),
                .total_out_divide(tod[g]),
                .div_enabled(div_enabled[g]),
                .out_clk(out_clk[g]),
                .out_oe(out_oe[g])
            ); // R05
        end
    endgenerate
    always_comb begin
        rdata = s_q.rdata;
        pll_power_down = {1'b0, s_q.ref_div[2] == 7'h00, s_q.ref_div[1] == 7'h00,
            s_q.ref_div[0] == 7'h00}; // R23
        fractional_pll_m = s_q.m_eff;
        pll1_m = s_q.fb_div[1]; // R02
        pll2_m = s_q.fb_div[2];
        pll3_m = s_q.fb_div[3];
        fractional_pll_ref_div = s_q.ref_div[0];
        pll1_ref_div = s_q.ref_div[1];
        pll2_ref_div = s_q.ref_div[2];
        pll3_ref_div = s_q.ref_div[3];
        ssc_mod_value = {5'h00, scaled};
        ssc_active = s_q.tssc != 4'h0; // R09
        undivided_output_en = s_q.ref_div[0] != 7'h00; // R05
    end
    sequence s_tick_off;
        pfd_tick && s_q.tssc == 4'h0;
    endsequence
    property p_off_nominal;
        @(posedge clk_sys) disable iff (!rst_n) s_tick_off |=> fractional_pll_m == $past(m_nom);
    endproperty
    a_off_nominal: assert property (p_off_nominal) else $error("ssc off not nominal"); // R09
    property p_hold_between;
        @(posedge clk_sys) disable iff (!rst_n) !pfd_tick |=> $stable(fractional_pll_m);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("m changed off tick"); // R24
    property p_pd;
        @(posedge clk_sys) disable iff (!rst_n) pll_power_down[0] == (fractional_pll_ref_div == 7'h00);
    endproperty
    a_pd: assert property (p_pd) else $error("power down mismatch"); // R23
    property p_frac;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.frac_a == 4'h0 |-> m_nom == {1'b0, s_q.fb_div[0], 1'b0};
    endproperty
    a_frac: assert property (p_frac) else $error("even m wrong"); // R02
    property p_step_len;
        @(posedge clk_sys) disable iff (!rst_n)
        pfd_tick && s_q.tssc != 4'h0 && !step_done |=> s_q.step_cnt == $past(s_q.step_cnt) + 5'h01;
    endproperty
    a_step_len: assert property (p_step_len) else $error("step count skip"); // R11
    property p_x2;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.amplitude_double |-> ssc_mod_value[0] == 1'b0;
    endproperty
    a_x2: assert property (p_x2) else $error("doubling odd"); // R20
    property p_start;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.tssc == 4'h0 ##1 s_q.tssc == 4'h0 |-> s_q.accum == {1'b0, $past(s_q.offset)};
    endproperty
    a_start: assert property (p_start) else $error("start not offset"); // R18
    property p_active;
        @(posedge clk_sys) disable iff (!rst_n) ssc_active == (s_q.tssc != 4'h0);
    endproperty
    a_active: assert property (p_active) else $error("active flag wrong"); // R09
    sequence s_step_tick;
        pfd_tick && s_q.tssc != 4'h0 && step_done;
    endsequence
    sequence s_quad_end;
        s_step_tick ##0 s_q.samp_idx >= nsamp - 4'h1 &&
            (s_q.quad == QUAD_UP_FALL || s_q.quad == QUAD_DN_RISE);
    endsequence
    property p_dn_grow;
        @(posedge clk_sys) disable iff (!rst_n)
        s_step_tick ##0 s_q.quad == QUAD_DN_FALL |=> s_q.accum >= $past(s_q.accum);
    endproperty
    a_dn_grow: assert property (p_dn_grow) else $error("lower half not mirrored"); // R13
    property p_quad_return;
        @(posedge clk_sys) disable iff (!rst_n)
        s_quad_end |=> s_q.accum == {1'b0, $past(s_q.offset)};
    endproperty
    a_quad_return: assert property (p_quad_return) else $error("quadrant pair not closed"); // R13
    property p_quad_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        s_q.tssc != 4'h0 && !(pfd_tick && step_done) |=> s_q.quad == $past(s_q.quad);
    endproperty
    a_quad_hold: assert property (p_quad_hold) else $error("quadrant moved mid step"); // R14
    property p_rd_idle;
        @(posedge clk_sys) disable iff (!rst_n) !rd_en |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read"); // R08
    property p_wr_tssc;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_en && addr == `SSC_IDX_TSSC |=> s_q.tssc == $past(wdata[3:0]);
    endproperty
    a_wr_tssc: assert property (p_wr_tssc) else $error("step period write lost"); // R08
endmodule // pll_divider_ssc_modulator

// >>> pll_divider_ssc_modulator_bench.sv
`timescale 1ns/1ps
`include "clkgen_regs.svh"
module pll_divider_ssc_modulator_bench import clkgen_pkg::*;;
    localparam int TS = 5;
    localparam int NS = 2;
    localparam int OF = 3;
    localparam int P = 4 * NS * 2 * (TS + 2);
    localparam int M0 = 206;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic pfd_tick = 1'b0;
    logic tick_en = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [3:0] pll_power_down;
    logic [13:0] fractional_pll_m, ssc_mod_value, m_prev;
    logic [11:0] pll1_m, pll2_m, pll3_m;
    logic [6:0] fractional_pll_ref_div, pll1_ref_div, pll2_ref_div, pll3_ref_div;
    logic ssc_active, undivided_output_en;
    logic [5:0] out_clk, out_oe, div_enabled;
    logic tick_prev = 1'b0;
    logic rst_prev = 1'b0;
    logic [31:0] rng = 32'h36;
    logic [7:0] dl[12];
    int error_cnt = 0;
    int n_tests = 0;
    int s0[$], s1[$], s2[$];

    pll_divider_ssc_modulator i_pll_divider_ssc_modulator (
        .clk_sys, .rst_n, .pfd_tick, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .pll_power_down, .fractional_pll_m, .pll1_m, .pll2_m, .pll3_m,
        .fractional_pll_ref_div, .pll1_ref_div, .pll2_ref_div, .pll3_ref_div,
        .ssc_mod_value, .ssc_active, .undivided_output_en, .out_clk, .out_oe,
        .div_enabled
    );

    always #5 clk_sys = ~clk_sys;
    // One detector pulse every second cycle while enabled
    always @(posedge clk_sys) pfd_tick <= tick_en & ~pfd_tick;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t %s: got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A change of the effective value must follow a detector pulse
    always @(negedge clk_sys) begin
        if (rst_n && rst_prev && fractional_pll_m !== m_prev && !tick_prev) begin
            chk(fractional_pll_m, m_prev, "feedback changed off detector edge");
        end
        m_prev = fractional_pll_m;
        tick_prev = pfd_tick;
        rst_prev = rst_n;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        tick_en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask

    task automatic setup_m0(input logic [7:0] a);
        wr(8'h04, 8'h64);
        wr(8'h08, 8'h00);
        wr(8'h0c, a);
    endtask

    task automatic period(input int i, output int p);
        int e[$];
        logic last;
        last = out_clk[i];
        for (int k = 0; k < 1000 && e.size() < 3; k++) begin
            @(negedge clk_sys);
            if (out_clk[i] === 1'b1 && last === 1'b0) e.push_back(k);
            last = out_clk[i];
        end
        p = (e.size() == 3) ? e[2] - e[1] : 0;
    endtask

    task automatic run_ssc(input logic [1:0] opt, output int s[$]);
        int plus = 0;
        int minus = 0;
        int pv = 0;
        s = {};
        @(posedge clk_sys);
        do_reset();
        setup_m0(8'h05);
        wr(`SSC_IDX_NSSC, 8'(NS));
        wr(`SSC_IDX_OFFS, 8'(OF));
        wr(`SSC_IDX_OPT, {6'h00, opt});
        for (int i = 0; i < 12; i++) wr(`SSC_IDX_SD0 + 8'(i), dl[i]);
        // Enable last so the waveform starts from the programmed offset
        wr(`SSC_IDX_TSSC, 8'(TS));
        tick_en <= 1'b1;
        for (int k = 0; k < 4 * P + 40 && s.size() < 2 * P + 8; k++) begin
            @(negedge clk_sys);
            if (pfd_tick === 1'b0) begin
                s.push_back(int'(ssc_mod_value));
                if (s.size() > 8) begin
                    // The value just applied was shown before the detector pulse
                    pv = s[s.size() - 2];
                    if (fractional_pll_m === 14'(M0 - 1 + pv)) plus++;
                    else if (fractional_pll_m === 14'(M0 - 1 - pv)) minus++;
                    else chk(fractional_pll_m, 14'(M0 - 1 + pv), "spread base");
                end
            end
        end
        if (s.size() < 2 * P + 8) begin
            error_cnt++;
            final_report();
        end
        chk(16'(plus > 0 && minus > 0), 16'h0001, "both spread polarities");
    endtask

    initial begin
        logic [7:0] rv[4];
        logic [11:0] nv[4];
        logic [7:0] d;
        logic [6:0] q;
        logic pm;
        logic [1:0] md;
        int p, ep, len, mn, nd;
        for (int i = 0; i < 12; i++) dl[i] = 8'(xs() % 15 + 1);
        do_reset();
        repeat (2) @(posedge clk_sys);
        #1;
        chk(pll_power_down, 4'h7, "reset power down");
        chk(out_oe, 6'h3f, "reset drive enable");
        chk(ssc_active, 1'b0, "reset spread off");
        $display("Test reset done");
        rv = '{8'(xs() % 127 + 1), 8'h00, 8'(xs() % 127 + 1), 8'h00};
        for (int i = 0; i < 4; i++) wr(8'(i), rv[i]);
        for (int i = 1; i < 4; i++) begin
            nv[i] = 12'(xs());
            wr(8'h04 + 8'(i), nv[i][7:0]);
            wr(8'h08 + 8'(i), {4'h0, nv[i][11:8]});
        end
        @(posedge clk_sys);
        #1;
        chk(fractional_pll_ref_div, rv[0][6:0], "ref div 0");
        chk(pll1_ref_div, rv[1][6:0], "ref div 1");
        chk(pll2_ref_div, rv[2][6:0], "ref div 2");
        chk(pll3_ref_div, rv[3][6:0], "ref div 3");
        chk(pll_power_down, {1'b0, rv[2] == 0, rv[1] == 0, rv[0] == 0}, "power down");
        chk(undivided_output_en, 1'b1, "undivided output on");
        chk(pll1_m, nv[1], "pll1 m");
        chk(pll2_m, nv[2], "pll2 m");
        chk(pll3_m, nv[3], "pll3 m");
        setup_m0(8'h00);
        tick_en <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 chk(fractional_pll_m, 14'd200, "m0 even");
        setup_m0(8'h05);
        wr(8'h00, 8'h00);
        repeat (6) @(posedge clk_sys);
        #1 chk(fractional_pll_m, 14'(M0), "m0 fractional");
        chk(undivided_output_en, 1'b0, "undivided output off");
        chk(pll_power_down[0], 1'b1, "fractional_pll power down");
        $display("Test pll dividers done");
        for (int c = 0; c < 9; c++) begin
            q = (c == 2) ? 7'h7e : (c == 3) ? 7'(xs() % 126) : (c > 3) ? 7'h7f : 7'h00;
            pm = c < 5 && c != 1;
            md = (c == 5) ? ODM_LOW : (c == 6) ? ODM_HIGH : (c == 7) ? ODM_HIZ : ODM_RSVD;
            wr(`CTRL_IDX_DIV + 8'(c % 6), {pm, q});
            wr(8'h18 + 8'(c % 6), {6'h00, md});
            ep = (q != 7'h7f) ? (pm ? (int'(q) + 2) * 2 : 2) : 0;
            period(c % 6, p);
            chk(16'(p), 16'(ep), "divider period");
            if (p == 0 && ep != 0) final_report();
            if (ep == 0) chk(out_clk[c % 6], pm | (md == ODM_HIGH), "static level");
            chk(out_oe[c % 6], !(q == 7'h7f && !pm && md == ODM_HIZ), "drive enable");
            chk(div_enabled[c % 6], !(q == 7'h7f && !pm), "divider enabled");
        end
        $display("Test output dividers done");
        run_ssc(2'b01, s2);
        run_ssc(2'b10, s1);
        run_ssc(2'b00, s0);
        len = 0;
        mn = 999;
        nd = 0;
        for (int k = 9; k < s0.size(); k++) begin
            if (s0[k] != s0[k - 1]) begin
                if (len > 0) chk(16'(len % (TS + 2)), 16'h0000, "step hold");
                len = 1;
            end else if (len > 0) len++;
        end
        for (int k = 8; k < 8 + P; k++) begin
            chk(16'(s0[k + P]), 16'(s0[k]), "modulation period");
            mn = (s0[k] < mn) ? s0[k] : mn;
        end
        chk(16'(mn), 16'(OF), "waveform floor");
        for (int k = 8; k < s0.size(); k++) begin
            chk(16'(s1[k]), 16'(2 * s0[k]), "doubled amplitude");
            chk(16'(s2[k] >> 1), 16'(s0[k] >> 1), "dither upper bits");
            nd += int'(s2[k] != s0[k]);
        end
        chk(16'(nd > 0), 16'h0001, "dither active");
        chk(ssc_active, 1'b1, "spread active");
        rd(`STAT_IDX_SSC, d);
        chk(d[0], 1'b1, "status active");
        rd(`CFG_SSC_FIRST, d);
        chk(d, 8'(TS), "step period readback");
        rd(`SSC_IDX_SD0 + 8'h0b, d);
        chk(d, dl[11], "last delta readback");
        rd(8'hfe, d);
        chk(d, 8'h00, "unmapped read");
        wr(`SSC_IDX_TSSC, 8'h00);
        repeat (20) @(posedge clk_sys);
        #1 chk(ssc_active, 1'b0, "spread stopped");
        chk(fractional_pll_m, 14'(M0), "nominal after stop");
        $display("Test spread spectrum done");
        final_report();
    end
endmodule // pll_divider_ssc_modulator_bench
